// ---- core/ep_consts.svh ----
`ifndef EP_CONSTS_SVH
`define EP_CONSTS_SVH

// ----------------------------------------------------------------
// Endpoint register offsets
// ----------------------------------------------------------------
`define EP_OFS_CSR   2'h0
`define EP_OFS_FIFO  2'h1
`define EP_OFS_RST   2'h2

// ----------------------------------------------------------------
// Status bits read at the control/status offset
// ----------------------------------------------------------------
`define EP_B_TX_COMPLETE  0
`define EP_B_RX0     1
`define EP_B_RX1     2
`define EP_B_STSENT  3
`define EP_B_TXRDY   4
`define EP_B_FSTALL  5
`define EP_B_CNT     16

// ----------------------------------------------------------------
// Command bits written at the control/status offset
// ----------------------------------------------------------------
`define EP_C_SETRDY  0
`define EP_C_CLRRDY  1
`define EP_C_CLRCOMP 2
`define EP_C_CLRRX0  3
`define EP_C_CLRRX1  4
`define EP_C_CLRSTS  5
`define EP_C_SETST   6
`define EP_C_CLRST   7

// ----------------------------------------------------------------
// Controller register offsets and bits
// ----------------------------------------------------------------
`define FW_OFS_STAT   3'h0
`define FW_OFS_TXDATA 3'h1
`define FW_OFS_COMMIT 3'h2
`define FW_OFS_RXDATA 3'h3
`define FW_OFS_RXDONE 3'h4
`define FW_OFS_CTRL   3'h5
`define FW_K_SETST    0
`define FW_K_CLRST    1
`define FW_K_CLRSTS   2
`define FW_K_CANCEL   3
`define FW_S_BUSY     8
`define FW_S_RXAV     9
`define FW_S_RXNEXT   10

// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define EP_SIZE_DEF  64
`define EP_RST_WORD  32'h0000_0000

`endif

// ---- core/ep_pkg.sv ----
package ep_pkg;
  typedef enum logic [1:0] {
    TOK_IN    = 2'h0,
    TOK_OUT   = 2'h1,
    TOK_SETUP = 2'h2
  } tok_t;

  typedef enum logic [1:0] {
    HS_ACK   = 2'h0,
    HS_NAK   = 2'h1,
    HS_STALL = 2'h2
  } hs_t;

  typedef enum logic [2:0] {
    D_IDLE     = 3'h0,
    D_IN_SEND  = 3'h1,
    D_IN_WAIT  = 3'h2,
    D_OUT_DATA = 3'h3
  } dev_st_t;
endpackage

// ---- core/ep_if.sv ----
`timescale 1ns/1ps
interface ep_if;
  logic [1:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        irq;

  modport dev (input addr, input wdata, input wr, input rd, output rdata, output irq);
  modport fw  (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface

// ---- core/usb_ep_bank.sv ----
// How it works
// - Ping-pong endpoint has two banks, one each side
// - Firmware loads bank 0 once ready clear
// - Firmware may fill bank 1 right after arming
// - Bank release sets tx_complete, interrupt pending
// - Firmware re-arms ready for bank 1 after complete
// - IN token without armed bank gets NAK
// - tx_complete set only on host ACK
// - Single-bank OUT: NAK while busy, else ACK
// - Stored OUT packet sets bank-0 flag, interrupt
// - Byte count shown, data read via FIFO port
// - Firmware reads data before clearing bank flag
// - Ping-pong OUT fills bank 0 then bank 1
// - Bank-1 packet sets its flag, interrupt either flag
// - Cleared bank 0 accepts next OUT again
// - Firmware clears bank flags strictly alternately
// - Force-stall answers transactions with STALL
// - STALL sent sets stall_sent until cleared
// - Functional stall for halt, protocol for control
// - Firmware clears stall_sent when setup arrives
// - Cancel clears ready, reset clears FIFO pointers
// - Isochronous traffic only on ping-pong endpoints
`timescale 1ns/1ps
`include "ep_consts.svh"
module usb_ep_bank #(
  parameter int EP_SIZE   = `EP_SIZE_DEF,
  parameter bit PING_PONG = 1'b1
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  // Firmware side
  ep_if.dev                  bus,
  // Token from the link
  input  wire logic          tok_valid_i,
  input  wire ep_pkg::tok_t  tok_kind_i,
  // OUT data from the link
  input  wire logic          rx_valid_i,
  input  wire logic [7:0]    rx_data_i,
  input  wire logic          rx_end_i,
  // IN data toward the link
  output logic               tx_valid_o,
  output logic [7:0]         tx_data_o,
  output logic               tx_last_o,
  output logic               tx_empty_o,
  input  wire logic          tx_ready_i,
  // Host handshake for IN
  input  wire logic          host_ack_i,
  input  wire logic          host_timeout_i,
  // Device handshake
  output logic               hs_valid_o,
  output ep_pkg::hs_t        hs_code_o
);
  import ep_pkg::*;

  localparam int NB = PING_PONG ? 2 : 1;
  localparam int AW = $clog2(EP_SIZE);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] SIZE_C = CW'(EP_SIZE);

  if (EP_SIZE < 8 || EP_SIZE > 512 || (EP_SIZE & (EP_SIZE - 1)) != 0) begin : g_bad_size
    $error("EP_SIZE must be a power of two from 8 to 512");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dev_st_t                st;
    logic [NB-1:0]          tx_full;
    logic [NB-1:0][CW-1:0]  tx_cnt;
    logic [NB-1:0]          rx_full;
    logic [NB-1:0][CW-1:0]  rx_cnt;
    logic                   fw_tx;
    logic                   usb_tx;
    logic                   fw_rx;
    logic                   usb_rx;
    logic [CW-1:0]          fw_ptr;
    logic [CW-1:0]          usb_ptr;
    logic                   tx_comp;
    logic                   st_sent;
    logic                   fstall;
    logic                   out_ok;
    logic                   hs_v;
    hs_t                    hs;
    logic [7:0]             tx_byte;
    logic [31:0]            rdata;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  // Two banks share one array; bank bit stays 0 without ping-pong
  logic [7:0]  mem [NB*EP_SIZE];
  logic        mw_u;
  logic        mw_f;
  logic [AW:0] mwa_u;
  logic [AW:0] mwa_f;
  logic [7:0]  mwd_f;

  function automatic logic [AW:0] maddr(input logic b, input logic [CW-1:0] p);
    return {b, p[AW-1:0]};
  endfunction

  function automatic logic nbank(input logic b);
    return PING_PONG ? ~b : 1'b0;
  endfunction

  function automatic logic [31:0] status(input st_t s);
    logic [31:0] v;
    v = `EP_RST_WORD;
    v[`EP_B_TX_COMPLETE] = s.tx_comp;
    v[`EP_B_RX0]    = s.rx_full[0];
    v[`EP_B_RX1]    = PING_PONG ? s.rx_full[NB-1] : 1'b0;
    v[`EP_B_STSENT] = s.st_sent;
    v[`EP_B_TXRDY]  = |s.tx_full;
    v[`EP_B_FSTALL] = s.fstall;
    v[`EP_B_CNT +: CW] = s.rx_cnt[s.fw_rx];
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic last;
    s_nxt = s_r;
    s_nxt.hs_v = 1'b0;
    mw_u  = 1'b0;
    mw_f  = 1'b0;
    mwa_u = maddr(s_r.usb_rx, s_r.usb_ptr);
    mwa_f = maddr(s_r.fw_tx, s_r.fw_ptr);
    mwd_f = bus.wdata[7:0];
    last  = (s_r.tx_cnt[s_r.usb_tx] == '0) ||
            (s_r.usb_ptr == s_r.tx_cnt[s_r.usb_tx] - 1'b1);

    // Firmware side first, so hardware sets below win over clears
    if (bus.rd) begin
      if (bus.addr == `EP_OFS_CSR) begin
        s_nxt.rdata = status(s_r);
      end else if (bus.addr == `EP_OFS_FIFO && s_r.fw_ptr < s_r.rx_cnt[s_r.fw_rx]) begin
        s_nxt.rdata = {24'h00_0000, mem[maddr(s_r.fw_rx, s_r.fw_ptr)]};
        s_nxt.fw_ptr = s_r.fw_ptr + 1'b1;
      end else begin
        s_nxt.rdata = `EP_RST_WORD;
      end
    end
    if (bus.wr) begin
      case (bus.addr)
        `EP_OFS_FIFO: begin
          // Writes to an armed bank are dropped, not queued
          if (!s_r.tx_full[s_r.fw_tx] && s_r.fw_ptr < SIZE_C) begin
            mw_f = 1'b1;
            s_nxt.fw_ptr = s_r.fw_ptr + 1'b1;
          end
        end
        `EP_OFS_CSR: begin
          if (bus.wdata[`EP_C_SETRDY] && !s_r.tx_full[s_r.fw_tx]) begin
            s_nxt.tx_full[s_r.fw_tx] = 1'b1;
            s_nxt.tx_cnt[s_r.fw_tx]  = s_r.fw_ptr;
            s_nxt.fw_tx  = nbank(s_r.fw_tx);
            s_nxt.fw_ptr = '0;
          end
          if (bus.wdata[`EP_C_CLRRDY]) begin
            s_nxt.tx_full = '0;
            s_nxt.fw_tx   = s_r.usb_tx;
          end
          if (bus.wdata[`EP_C_CLRCOMP]) begin
            s_nxt.tx_comp = 1'b0;
          end
          if (bus.wdata[`EP_C_CLRRX0] && s_r.rx_full[0]) begin
            s_nxt.rx_full[0] = 1'b0;
            s_nxt.fw_rx  = nbank(1'b0);
            s_nxt.fw_ptr = '0;
          end
          if (PING_PONG && bus.wdata[`EP_C_CLRRX1] && s_r.rx_full[NB-1]) begin
            s_nxt.rx_full[NB-1] = 1'b0;
            s_nxt.fw_rx  = 1'b0;
            s_nxt.fw_ptr = '0;
          end
          if (bus.wdata[`EP_C_CLRSTS]) begin
            s_nxt.st_sent = 1'b0;
          end
          if (bus.wdata[`EP_C_SETST]) begin
            s_nxt.fstall = 1'b1;
          end
          if (bus.wdata[`EP_C_CLRST]) begin
            s_nxt.fstall = 1'b0;
          end
        end
        `EP_OFS_RST: begin
          // Endpoint reset drops banks and pointers, keeps the stall request
          s_nxt.tx_full = '0;
          s_nxt.rx_full = '0;
          s_nxt.fw_tx   = 1'b0;
          s_nxt.usb_tx  = 1'b0;
          s_nxt.fw_rx   = 1'b0;
          s_nxt.usb_rx  = 1'b0;
          s_nxt.fw_ptr  = '0;
          s_nxt.usb_ptr = '0;
          s_nxt.tx_comp = 1'b0;
          s_nxt.st      = D_IDLE;
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Link side
    // ----------------------------------------------------------------
    case (s_r.st)
      D_IDLE: begin
        if (tok_valid_i && tok_kind_i == TOK_IN) begin
          if (s_r.fstall) begin
            s_nxt.hs_v    = 1'b1;
            s_nxt.hs      = HS_STALL;
            s_nxt.st_sent = 1'b1;
          end else if (s_r.tx_full[s_r.usb_tx]) begin
            s_nxt.st      = D_IN_SEND;
            s_nxt.usb_ptr = '0;
            s_nxt.tx_byte = mem[maddr(s_r.usb_tx, '0)];
          end else begin
            s_nxt.hs_v = 1'b1;
            s_nxt.hs   = HS_NAK;
          end
        end else if (tok_valid_i && tok_kind_i == TOK_OUT) begin
          s_nxt.st      = D_OUT_DATA;
          s_nxt.usb_ptr = '0;
          s_nxt.out_ok  = !s_r.fstall && !s_r.rx_full[s_r.usb_rx];
        end
      end
      D_IN_SEND: begin
        if (tx_ready_i) begin
          if (last) begin
            s_nxt.st = D_IN_WAIT;
          end else begin
            s_nxt.usb_ptr = s_r.usb_ptr + 1'b1;
            s_nxt.tx_byte = mem[maddr(s_r.usb_tx, s_r.usb_ptr + 1'b1)];
          end
        end
      end
      D_IN_WAIT: begin
        if (host_ack_i) begin
          s_nxt.tx_full[s_r.usb_tx] = 1'b0;
          s_nxt.tx_comp = 1'b1;
          s_nxt.usb_tx  = nbank(s_r.usb_tx);
          s_nxt.st      = D_IDLE;
        end else if (host_timeout_i) begin
          // Bank stays armed so the host's retry gets the same data
          s_nxt.st = D_IDLE;
        end
      end
      D_OUT_DATA: begin
        if (rx_end_i) begin
          s_nxt.st   = D_IDLE;
          s_nxt.hs_v = 1'b1;
          if (s_r.fstall) begin
            s_nxt.hs      = HS_STALL;
            s_nxt.st_sent = 1'b1;
          end else if (s_r.out_ok) begin
            s_nxt.hs = HS_ACK;
            s_nxt.rx_full[s_r.usb_rx] = 1'b1;
            s_nxt.rx_cnt[s_r.usb_rx]  = s_r.usb_ptr;
            s_nxt.usb_rx = nbank(s_r.usb_rx);
          end else begin
            s_nxt.hs = HS_NAK;
          end
        end else if (rx_valid_i && s_r.out_ok && s_r.usb_ptr < SIZE_C) begin
          mw_u = 1'b1;
          s_nxt.usb_ptr = s_r.usb_ptr + 1'b1;
        end
      end
      default: begin
        s_nxt.st = D_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (mw_u) begin
      mem[mwa_u] <= rx_data_i;
    end
    if (mw_f) begin
      mem[mwa_f] <= mwd_f;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.rdata  = s_r.rdata;
  assign bus.irq    = s_r.tx_comp | (|s_r.rx_full) | s_r.st_sent;
  assign tx_valid_o = (s_r.st == D_IN_SEND);
  assign tx_data_o  = s_r.tx_byte;
  assign tx_empty_o = (s_r.st == D_IN_SEND) && (s_r.tx_cnt[s_r.usb_tx] == '0);
  assign tx_last_o  = (s_r.st == D_IN_SEND) &&
                      ((s_r.tx_cnt[s_r.usb_tx] == '0) ||
                       (s_r.usb_ptr == s_r.tx_cnt[s_r.usb_tx] - 1'b1));
  assign hs_valid_o = s_r.hs_v;
  assign hs_code_o  = s_r.hs;
endmodule

// ---- core/ep_fw_ctrl.sv ----
`timescale 1ns/1ps
`include "ep_consts.svh"
module ep_fw_ctrl #(
  parameter bit PING_PONG = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Endpoint side
  ep_if.fw                 bus,
  // Software port
  input  wire logic [2:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o
);
  import ep_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        pend_arm;
    logic        fresh;
    logic        poll_fl;
    logic        fwd_rd;
    logic        rx_next;
    logic        cancel;
    logic [31:0] stat;
    logic [31:0] rdata;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  function automatic logic [31:0] cmd(input int b);
    logic [31:0] v;
    v = `EP_RST_WORD;
    v[b] = 1'b1;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state and endpoint bus
  // ----------------------------------------------------------------
  always_comb begin
    logic busy;
    logic sw_bus;
    s_nxt = s_r;
    s_nxt.fwd_rd = 1'b0;
    bus.addr  = `EP_OFS_CSR;
    bus.wdata = `EP_RST_WORD;
    bus.wr    = 1'b0;
    bus.rd    = 1'b0;
    // Single bank: an armed bank cannot take bytes
    busy   = s_r.pend_arm | (!PING_PONG & s_r.stat[`EP_B_TXRDY]);
    sw_bus = 1'b0;
    if (s_r.poll_fl) begin
      s_nxt.stat    = bus.rdata;
      s_nxt.fresh   = 1'b1;
      s_nxt.poll_fl = 1'b0;
    end
    if (wr_i) begin
      sw_bus = 1'b1;
      case (addr_i)
        `FW_OFS_TXDATA: begin
          if (!busy) begin
            bus.addr  = `EP_OFS_FIFO;
            bus.wdata = wdata_i;
            bus.wr    = 1'b1;
          end
        end
        `FW_OFS_COMMIT: begin
          s_nxt.pend_arm = 1'b1;
        end
        `FW_OFS_RXDONE: begin
          bus.wr    = 1'b1;
          bus.wdata = cmd(s_r.rx_next ? `EP_C_CLRRX1 : `EP_C_CLRRX0);
          s_nxt.rx_next = PING_PONG ? ~s_r.rx_next : 1'b0;
        end
        `FW_OFS_CTRL: begin
          bus.wr = 1'b1;
          bus.wdata[`EP_C_SETST]  = wdata_i[`FW_K_SETST];
          bus.wdata[`EP_C_CLRST]  = wdata_i[`FW_K_CLRST];
          bus.wdata[`EP_C_CLRSTS] = wdata_i[`FW_K_CLRSTS];
          bus.wdata[`EP_C_CLRRDY] = wdata_i[`FW_K_CANCEL];
          if (wdata_i[`FW_K_CANCEL]) begin
            s_nxt.cancel = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else if (rd_i && addr_i == `FW_OFS_RXDATA) begin
      sw_bus       = 1'b1;
      bus.addr     = `EP_OFS_FIFO;
      bus.rd       = 1'b1;
      s_nxt.fwd_rd = 1'b1;
    end
    if (rd_i && addr_i != `FW_OFS_RXDATA) begin
      s_nxt.rdata = (addr_i == `FW_OFS_STAT) ? s_r.stat : `EP_RST_WORD;
      s_nxt.rdata[`FW_S_BUSY]   = (addr_i == `FW_OFS_STAT) & busy;
      s_nxt.rdata[`FW_S_RXAV]   = (addr_i == `FW_OFS_STAT) &
                                  s_r.stat[s_r.rx_next ? `EP_B_RX1 : `EP_B_RX0];
      s_nxt.rdata[`FW_S_RXNEXT] = (addr_i == `FW_OFS_STAT) & s_r.rx_next;
    end

    // Own actions only on a free cycle; arm and complete-clear also need fresh status
    if (!sw_bus) begin
      if (s_r.cancel) begin
        bus.addr       = `EP_OFS_RST;
        bus.wr         = 1'b1;
        s_nxt.cancel   = 1'b0;
        s_nxt.pend_arm = 1'b0;
        s_nxt.rx_next  = 1'b0;
      end else if (s_r.fresh && s_r.pend_arm && !s_r.stat[`EP_B_TXRDY]) begin
        bus.wr         = 1'b1;
        bus.wdata      = cmd(`EP_C_SETRDY);
        s_nxt.pend_arm = 1'b0;
      end else if (s_r.fresh && !s_r.pend_arm && s_r.stat[`EP_B_TX_COMPLETE]) begin
        bus.wr    = 1'b1;
        bus.wdata = cmd(`EP_C_CLRCOMP);
      end else if (!s_r.poll_fl) begin
        // Poll every other spare cycle: link events set flags without any write
        bus.rd        = 1'b1;
        s_nxt.poll_fl = 1'b1;
      end
    end
    // Any write makes the held status stale
    if (bus.wr) begin
      s_nxt.fresh = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.fwd_rd ? bus.rdata : s_r.rdata;
endmodule

// ---- verif/ep_link_properties.sv ----
`timescale 1ns/1ps
module ep_link_props (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // Endpoint register bus
  input wire logic [1:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        irq,
  // Link side
  input wire logic        tok_valid_i,
  input wire ep_pkg::tok_t tok_kind_i,
  input wire logic        rx_end_i,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_last_o,
  input wire logic        tx_ready_i,
  input wire logic        host_ack_i,
  input wire logic        hs_valid_o,
  input wire ep_pkg::hs_t hs_code_o
);
  import ep_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_strobes_apart: assert property (!(wr && rd))
    else $error("Read and write strobes overlap");
  a_beat_holds: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("IN beat changed before it was taken");
  a_last_beat_ends: assert property (tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o)
    else $error("IN data went on after last beat");
  a_ack_sets_irq: assert property (host_ack_i |=> irq)
    else $error("Host ACK did not raise interrupt");
  a_irq_has_cause: assert property ($rose(irq) |->
      $past(host_ack_i) || $past(rx_end_i) || $past(tok_valid_i))
    else $error("Interrupt rose without an event");
  a_in_token_answer: assert property (tok_valid_i && tok_kind_i == TOK_IN |=>
      (hs_valid_o && hs_code_o != HS_ACK) || (tx_valid_o && !hs_valid_o))
    else $error("IN token got no proper answer");
  a_out_handshake: assert property (rx_end_i |=> hs_valid_o)
    else $error("OUT packet got no handshake");
  a_hs_single: assert property (hs_valid_o |=> !hs_valid_o)
    else $error("Handshake pulse longer than one cycle");
  a_stall_irq: assert property (hs_valid_o && hs_code_o == HS_STALL |-> ##[0:1] irq)
    else $error("Stall sent without interrupt");
  a_rx_ack_irq: assert property (hs_valid_o && hs_code_o == HS_ACK |-> ##[0:1] irq)
    else $error("Stored OUT packet without interrupt");
endmodule

// ---- verif/usb_endpoint_bank_handshake_tb_top.sv ----
`timescale 1ns/1ps
`include "ep_consts.svh"
module usb_endpoint_bank_handshake_tb_top;
  import ep_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [2:0]  addr_i = 3'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic        tok_valid_i = 1'b0;
  tok_t        tok_kind_i = TOK_IN;
  logic        rx_valid_i = 1'b0;
  logic [7:0]  rx_data_i = 8'h00;
  logic        rx_end_i = 1'b0;
  logic        tx_valid_o;
  logic [7:0]  tx_data_o;
  logic        tx_last_o;
  logic        tx_empty_o;
  logic        tx_ready_i = 1'b0;
  logic        host_ack_i = 1'b0;
  logic        host_timeout_i = 1'b0;
  logic        hs_valid_o;
  hs_t         hs_code_o;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          seed = 91681;
  logic        rd_d = 1'b0;
  logic [7:0]  b;
  hs_t         hs_q[$];
  logic [9:0]  tx_q[$];
  logic [9:0]  tx_e;
  logic [31:0] rd_q[$];
  logic [31:0] msk_q[$];
  logic [7:0]  rx_model[$];

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  ep_if ep_if_i ();
  usb_ep_bank #(.EP_SIZE(64), .PING_PONG(1'b1)) usb_ep_bank_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(ep_if_i.dev),
    .tok_valid_i(tok_valid_i), .tok_kind_i(tok_kind_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .rx_end_i(rx_end_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_empty_o(tx_empty_o),
    .tx_ready_i(tx_ready_i),
    .host_ack_i(host_ack_i), .host_timeout_i(host_timeout_i), .hs_valid_o(hs_valid_o),
    .hs_code_o(hs_code_o));
  ep_fw_ctrl #(.PING_PONG(1'b1)) ep_fw_ctrl_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(ep_if_i.fw), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  ep_link_props ep_link_props_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr(ep_if_i.addr), .wdata(ep_if_i.wdata),
    .wr(ep_if_i.wr), .rd(ep_if_i.rd), .rdata(ep_if_i.rdata), .irq(ep_if_i.irq),
    .tok_valid_i(tok_valid_i), .tok_kind_i(tok_kind_i), .rx_end_i(rx_end_i),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
    .tx_ready_i(tx_ready_i), .host_ack_i(host_ack_i), .hs_valid_o(hs_valid_o),
    .hs_code_o(hs_code_o));

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Oldest note is matched against each result as it shows up
  always @(posedge clk_i) begin
    rd_d <= rd_i;
    if (rd_d === 1'b1) begin
      if (rd_q.size() == 0) cmp(32'h1, 32'h0, "unexpected read");
      else cmp(rdata_o & msk_q.pop_front(), rd_q.pop_front(), "read data");
    end
    if (hs_valid_o === 1'b1) begin
      if (hs_q.size() == 0) cmp(32'h1, 32'h0, "unexpected handshake");
      else cmp({30'h0, hs_code_o}, {30'h0, hs_q.pop_front()}, "handshake");
    end
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      if (tx_q.size() == 0) cmp(32'h1, 32'h0, "unexpected IN beat");
      else begin
        tx_e = tx_q.pop_front();
        cmp({22'h0, tx_empty_o, tx_last_o, tx_e[9] ? 8'h00 : tx_data_o},
            {22'h0, tx_e}, "IN beat");
      end
    end
  end

  // Well above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    results();
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic sw_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic sw_rd(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  // Status snapshot needs idle cycles to refresh
  task automatic stat(input logic [31:0] e, input logic [31:0] m);
    idle(6);
    sw_rd(`FW_OFS_STAT, e, m);
  endtask

  task automatic tx_fill(input int n, output logic [9:0] q[$]);
    q = {};
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      q.push_back({1'b0, i == n - 1, b});
      sw_wr(`FW_OFS_TXDATA, {24'h0, b});
    end
    sw_wr(`FW_OFS_COMMIT, 32'h0);
  endtask

  task automatic rx_read(input int n);
    for (int i = 0; i < n; i++) sw_rd(`FW_OFS_RXDATA, {24'h0, rx_model.pop_front()}, 32'hFF);
    sw_wr(`FW_OFS_RXDONE, 32'h0);
  endtask

  // Ready toggles at random so beats must hold; timeout leaves bank for retry
  task automatic in_tok(input bit timeout, input logic [9:0] q[$]);
    foreach (q[i]) tx_q.push_back(q[i]);
    @(posedge clk_i);
    tok_valid_i <= 1'b1;
    tok_kind_i <= TOK_IN;
    @(posedge clk_i);
    tok_valid_i <= 1'b0;
    if (q.size() > 0) begin
      for (int i = 0; i < 300; i++) begin
        if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1 && tx_last_o === 1'b1) break;
        tx_ready_i <= 1'($random(seed));
        @(posedge clk_i);
      end
      tx_ready_i <= 1'b0;
      @(posedge clk_i);
      host_ack_i <= !timeout;
      host_timeout_i <= timeout;
      @(posedge clk_i);
      host_ack_i <= 1'b0;
      host_timeout_i <= 1'b0;
    end
    idle(3);
  endtask

  task automatic out_pkt(input int n, input hs_t code);
    hs_q.push_back(code);
    @(posedge clk_i);
    tok_valid_i <= 1'b1;
    tok_kind_i <= TOK_OUT;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      tok_valid_i <= 1'b0;
      b = 8'($random(seed));
      rx_valid_i <= 1'b1;
      rx_data_i <= b;
      if (code == HS_ACK) rx_model.push_back(b);
    end
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    rx_end_i <= 1'b1;
    @(posedge clk_i);
    rx_end_i <= 1'b0;
    idle(2);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [9:0] q0[$];
    logic [9:0] q1[$];
    logic [9:0] none[$];
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    idle(4);
    tx_fill(2, q0);
    stat(32'h10, 32'h110);
    tx_fill(3, q1);
    in_tok(1'b1, q0);
    in_tok(1'b0, q0);
    idle(8);
    in_tok(1'b0, q1);
    hs_q.push_back(HS_NAK);
    in_tok(1'b0, none);
    $display("ping-pong IN test done");
    out_pkt(2, HS_ACK);
    out_pkt(3, HS_ACK);
    out_pkt(1, HS_NAK);
    stat(32'h0002_0206, 32'h003F_0606);
    rx_read(2);
    stat(32'h0003_0604, 32'h003F_0606);
    rx_read(3);
    out_pkt(1, HS_ACK);
    stat(32'h0001_0202, 32'h003F_0606);
    rx_read(1);
    $display("ping-pong OUT test done");
    sw_wr(`FW_OFS_CTRL, 32'h1);
    idle(3);
    hs_q.push_back(HS_STALL);
    in_tok(1'b0, none);
    out_pkt(1, HS_STALL);
    stat(32'h28, 32'h28);
    sw_wr(`FW_OFS_CTRL, 32'h6);
    stat(32'h0, 32'h28);
    hs_q.push_back(HS_NAK);
    in_tok(1'b0, none);
    $display("stall test done");
    tx_fill(2, q0);
    idle(6);
    sw_wr(`FW_OFS_CTRL, 32'h8);
    stat(32'h0, 32'h10);
    hs_q.push_back(HS_NAK);
    in_tok(1'b0, none);
    tx_fill(1, q0);
    idle(6);
    in_tok(1'b0, q0);
    tx_fill(0, q0);
    idle(6);
    q0 = '{10'h300};
    in_tok(1'b0, q0);
    idle(4);
    cmp(hs_q.size() + tx_q.size() + rd_q.size(), 32'h0, "results left over");
    $display("cancel test done");
    results();
  end
endmodule
